// file: common/sfp_defines.svh
// Timing and opcode constants for the flash program and power controller
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH
`define SFP_CLK_MHZ 20
`define SFP_PROG_TIME_US 650
`define SFP_PROG_CYCLES (`SFP_PROG_TIME_US * `SFP_CLK_MHZ)
`define SFP_SLEEP_ENTRY_US 20
`define SFP_SLEEP_CYCLES (`SFP_SLEEP_ENTRY_US * `SFP_CLK_MHZ)
`define SFP_WAKE_DELAY_US 20
`define SFP_WAKE_CYCLES (`SFP_WAKE_DELAY_US * `SFP_CLK_MHZ)
`define SFP_OP_WRITE_LATCH_SET 8'h06
`define SFP_OP_PAGE_PROGRAM 8'h02
`define SFP_OP_DEEP_SLEEP 8'hb9
`define SFP_OP_WAKE 8'hab
`define SFP_PAGE_BYTES 32
`define SFP_FIFO_DEPTH 32
`endif

// file: common/sfp_pkg.sv
// Types shared by the flash program and power controller
`default_nettype none
package sfp_pkg;
    typedef struct packed {
        logic [23:0] addr;
        logic [7:0] data;
    } sfp_wr_s;
    typedef enum logic [3:0] {
        PW_STANDBY = 4'b0001,
        PW_ENTERING = 4'b0010,
        PW_SLEEP = 4'b0100,
        PW_WAKING = 4'b1000
    } sfp_pwr_e;
    typedef enum logic [4:0] {
        SH_OPCODE = 5'b00001,
        SH_ADDR = 5'b00010,
        SH_DATA = 5'b00100,
        SH_DONE = 5'b01000,
        SH_IGNORE = 5'b10000
    } sfp_shift_e;
endpackage
`default_nettype wire

// file: core/sfp_ctrl.sv
// Serial flash instruction handler: page program, deep sleep and wake
`include "sfp_defines.svh"
`default_nettype none
// Functional notes
// - Page program runs only while the write enable latch is set.
// - Bytes go sequentially from the start address, wrapping in 32-byte page.
// - Deselect must follow a whole data byte, else program is rejected.
// - Deselect starts program; busy flag high during, latch cleared after.
// - Program cycle lasts at most 650 microseconds.
// - Asleep, every instruction except wake is ignored.
// - Sleep is entered only after the entry delay from deselect.
// - Sleep entry delay does not exceed 20 microseconds.
// - Wake runs only if deselect follows exactly the eighth opcode bit.
// - Wake in standby stays in standby; during the entry delay the code starts the wake delay instead, and while waking it keeps waking.
// - Wake from sleep reaches standby after the wake delay.
// - Wake is not executed while a program cycle runs.
// - After reset: standby, write enable latch clear.
module sfp_ctrl #(
    parameter int PROG_CYCLES = `SFP_PROG_CYCLES,
    parameter int SLEEP_CYCLES = `SFP_SLEEP_CYCLES,
    parameter int WAKE_CYCLES = `SFP_WAKE_CYCLES,
    parameter int FIFO_DEPTH = `SFP_FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic si_i,
    output logic write_enable_latch_o,
    output logic write_in_progress_flag_o,
    output logic deep_sleep_o,
    output logic standby_o,
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output sfp_pkg::sfp_wr_s wr_o
);
    import sfp_pkg::*;
    localparam int CW = $clog2(PROG_CYCLES + 1);
    // Two-stage synchronisers on the serial pins
    logic [1:0] cs_sy, ck_sy, si_sy;
    logic cs_q, ck_q;
    logic [7:0] shreg, next_shreg;
    logic [2:0] bitcnt, next_bitcnt;
    logic [1:0] addrcnt, next_addrcnt;
    logic [23:0] addr, next_addr;
    logic [7:0] opcode, next_opcode;
    sfp_shift_e sh, next_sh;
    logic got_data, next_got_data;
    logic byte_ok, next_byte_ok;
    logic write_enable_latch, next_wel;
    logic write_in_progress_flag, next_wip;
    sfp_pwr_e pw, next_pw;
    logic [CW-1:0] tmr, next_tmr;
    logic sclk_rise, cs_fall, cs_rise, byte_done;
    logic f_valid, f_ready, o_valid, flush;
    sfp_wr_s f_data, o_data;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cs_sy <= 2'h3;
            ck_sy <= 2'h0;
            si_sy <= 2'h0;
            cs_q <= 1'b1;
            ck_q <= 1'b0;
        end else begin
            cs_sy <= {cs_sy[0], cs_n_i};
            ck_sy <= {ck_sy[0], sclk_i};
            si_sy <= {si_sy[0], si_i};
            cs_q <= cs_sy[1];
            ck_q <= ck_sy[1];
        end
    end
    assign sclk_rise = ck_sy[1] && !ck_q && !cs_sy[1];
    assign cs_fall = !cs_sy[1] && cs_q;
    assign cs_rise = cs_sy[1] && !cs_q;
    assign byte_done = sclk_rise && (bitcnt == 3'h7);
    // Shifter and decoder; data bytes are pushed into the FIFO as they complete
    always_comb begin
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_addrcnt = addrcnt;
        next_addr = addr;
        next_opcode = opcode;
        next_sh = sh;
        next_got_data = got_data;
        next_byte_ok = byte_ok;
        f_valid = 1'b0;
        f_data = '{addr: addr, data: {shreg[6:0], si_sy[1]}};
        if (cs_fall) begin
            next_sh = SH_OPCODE;
            next_bitcnt = 3'h0;
            next_addrcnt = 2'h0;
            next_got_data = 1'b0;
            next_byte_ok = 1'b1;
        end else if (sclk_rise) begin
            next_shreg = {shreg[6:0], si_sy[1]};
            next_bitcnt = bitcnt + 3'h1;
            next_byte_ok = byte_done;
            if (byte_done) begin
                case (sh)
                    SH_OPCODE: begin
                        next_opcode = next_shreg;
                        // Entering, asleep or waking: anything but wake is dropped
                        if (pw != PW_STANDBY && next_shreg != `SFP_OP_WAKE)
                            next_sh = SH_IGNORE;
                        else if (next_shreg == `SFP_OP_PAGE_PROGRAM
                                 && write_enable_latch && !write_in_progress_flag)
                            next_sh = SH_ADDR;
                        else
                            next_sh = SH_DONE;
                    end
                    SH_ADDR: begin
                        next_addr = {addr[15:0], next_shreg};
                        next_addrcnt = addrcnt + 2'h1;
                        if (addrcnt == 2'h2)
                            next_sh = SH_DATA;
                    end
                    SH_DATA: begin
                        // Bytes beyond a full page are dropped, not stalled
                        f_valid = f_ready;
                        next_got_data = 1'b1;
                        // Offset wraps inside the page
                        next_addr = {addr[23:5], addr[4:0] + 5'h01};
                    end
                    SH_DONE: next_sh = SH_IGNORE;
                    default: next_sh = SH_IGNORE;
                endcase
            end
        end
    end
    assign flush = cs_rise && sh == SH_DATA && !(got_data && byte_ok);
    // Power state, program cycle and write enable latch
    always_comb begin
        next_wel = write_enable_latch;
        next_wip = write_in_progress_flag;
        next_pw = pw;
        next_tmr = tmr;
        if (write_in_progress_flag) begin
            if (tmr == CW'(1)) begin
                next_wip = 1'b0;
                next_wel = 1'b0;
            end else begin
                next_tmr = tmr - CW'(1);
            end
        end
        case (pw)
            PW_ENTERING, PW_WAKING: begin
                if (tmr == CW'(1))
                    next_pw = (pw == PW_ENTERING) ? PW_SLEEP : PW_STANDBY;
                else
                    next_tmr = tmr - CW'(1);
            end
            default: ;
        endcase
        if (cs_rise && byte_ok) begin
            if (sh == SH_DATA && got_data) begin
                next_wip = 1'b1;
                next_tmr = CW'(PROG_CYCLES);
            end else if (sh == SH_DONE && !write_in_progress_flag) begin
                case (opcode)
                    `SFP_OP_WRITE_LATCH_SET:
                        if (pw == PW_STANDBY) next_wel = 1'b1;
                    `SFP_OP_DEEP_SLEEP:
                        if (pw == PW_STANDBY) begin
                            next_pw = PW_ENTERING;
                            next_tmr = CW'(SLEEP_CYCLES);
                        end
                    `SFP_OP_WAKE:
                        if (pw == PW_SLEEP || pw == PW_ENTERING) begin
                            next_pw = PW_WAKING;
                            next_tmr = CW'(WAKE_CYCLES);
                        end else if (pw == PW_WAKING) begin
                            next_pw = PW_WAKING;
                        end else begin
                            next_pw = PW_STANDBY;
                        end
                    default: ;
                endcase
            end
        end
    end
    // Wake during a program cycle is refused by the !wip guard above
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            shreg <= 8'h00;
            bitcnt <= 3'h0;
            addrcnt <= 2'h0;
            addr <= 24'h000000;
            opcode <= 8'h00;
            sh <= SH_IGNORE;
            got_data <= 1'b0;
            byte_ok <= 1'b0;
            write_enable_latch <= 1'b0;
            write_in_progress_flag <= 1'b0;
            pw <= PW_STANDBY;
            tmr <= '0;
        end else begin
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            addrcnt <= next_addrcnt;
            addr <= next_addr;
            opcode <= next_opcode;
            sh <= next_sh;
            got_data <= next_got_data;
            byte_ok <= next_byte_ok;
            write_enable_latch <= next_wel;
            write_in_progress_flag <= next_wip;
            pw <= next_pw;
            tmr <= next_tmr;
        end
    end
    // Bytes are held until the frame is accepted; a rejected frame is
    // flushed, and array writes are released only once programming starts.
    sfp_fifo #(.WIDTH($bits(sfp_wr_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .flush_i(flush),
        .in_valid_i(f_valid),
        .in_ready_o(f_ready),
        .in_data_i(f_data),
        .out_valid_o(o_valid),
        .out_ready_i(write_in_progress_flag && (!wr_valid_o || wr_ready_i)),
        .out_data_o(o_data)
    );
    logic next_wr_valid;
    sfp_wr_s next_wr;
    always_comb begin
        next_wr_valid = wr_valid_o;
        next_wr = wr_o;
        if (wr_valid_o && wr_ready_i)
            next_wr_valid = 1'b0;
        if (write_in_progress_flag && o_valid && (!wr_valid_o || wr_ready_i)) begin
            next_wr_valid = 1'b1;
            next_wr = o_data;
        end
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_valid_o <= 1'b0;
            wr_o <= '0;
            write_enable_latch_o <= 1'b0;
            write_in_progress_flag_o <= 1'b0;
            deep_sleep_o <= 1'b0;
            standby_o <= 1'b1;
        end else begin
            wr_valid_o <= next_wr_valid;
            wr_o <= next_wr;
            write_enable_latch_o <= next_wel;
            write_in_progress_flag_o <= next_wip;
            deep_sleep_o <= (next_pw == PW_SLEEP);
            standby_o <= (next_pw == PW_STANDBY);
        end
    end
endmodule // sfp_ctrl
`default_nettype wire

// file: core/sfp_fifo.sv
// Parameterised flop-based FIFO with valid/ready on both sides
`default_nettype none
module sfp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;
    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule // sfp_fifo
`default_nettype wire

// file: verif/sfp_ctrl_checker.sv
// Port-level assertions for the flash instruction handler
`default_nettype none
module sfp_ctrl_checker #(
    parameter int SLEEP_CYCLES = 400,
    parameter int PROG_CYCLES = 13000
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic write_enable_latch_o,
    input wire logic write_in_progress_flag_o,
    input wire logic deep_sleep_o,
    input wire logic standby_o,
    input wire logic wr_valid_o,
    input wire logic wr_ready_i,
    input wire sfp_pkg::sfp_wr_s wr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import sfp_pkg::*;
    // Busy length is counted here, far too long for a repetition
    int busy_cnt;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= write_in_progress_flag_o ? busy_cnt + 1 : 0;
        end
    end
    // Slack beyond the entry timer; standby_o falls in the cycle the entry timer starts
    localparam int ENTRY_MAX = SLEEP_CYCLES + 6;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Holds only while the wake delay is at least eight cycles
    sequence s_wake_wait;
        !standby_o [*8];
    endsequence
    property p_rst;
        $fell(rst_i) |-> standby_o && !write_enable_latch_o &&
            !write_in_progress_flag_o;
    endproperty
    property p_latch;
        $rose(write_in_progress_flag_o) |-> $past(write_enable_latch_o);
    endproperty
    property p_clear;
        $fell(write_in_progress_flag_o) |-> !write_enable_latch_o;
    endproperty
    property p_hold;
        $rose(write_in_progress_flag_o) |-> write_in_progress_flag_o [*8];
    endproperty
    property p_asleep;
        $rose(write_in_progress_flag_o) |-> !$past(deep_sleep_o);
    endproperty
    property p_mode;
        deep_sleep_o |-> !standby_o && !write_in_progress_flag_o;
    endproperty
    property p_max;
        write_in_progress_flag_o |-> busy_cnt < PROG_CYCLES;
    endproperty
    property p_enter;
        $rose(deep_sleep_o) |-> !$past(standby_o);
    endproperty
    property p_entry;
        $fell(standby_o) |-> ##[1:ENTRY_MAX] deep_sleep_o;
    endproperty
    property p_wake;
        $fell(deep_sleep_o) |-> s_wake_wait;
    endproperty
    property p_wr;
        wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_o);
    endproperty
    a_rst: assert property (p_rst)
        else $error("bad state after reset");
    a_latch: assert property (p_latch)
        else $error("program without latch");
    a_clear: assert property (p_clear)
        else $error("latch set after program");
    a_hold: assert property (p_hold)
        else $error("program cycle too short");
    a_asleep: assert property (p_asleep)
        else $error("program while asleep");
    a_mode: assert property (p_mode)
        else $error("standby or program while asleep");
    a_max: assert property (p_max)
        else $error("program cycle too long");
    a_enter: assert property (p_enter)
        else $error("sleep without entry delay");
    a_entry: assert property (p_entry)
        else $error("sleep entry too slow");
    a_wake: assert property (p_wake)
        else $error("wake without delay");
    a_wr: assert property (p_wr)
        else $error("array write dropped");
endmodule // sfp_ctrl_checker
bind sfp_ctrl sfp_ctrl_checker #(.SLEEP_CYCLES(SLEEP_CYCLES),
    .PROG_CYCLES(PROG_CYCLES)) u_chk (
    .clock_i(clock_i), .rst_i(rst_i),
    .write_enable_latch_o(write_enable_latch_o),
    .write_in_progress_flag_o(write_in_progress_flag_o),
    .deep_sleep_o(deep_sleep_o), .standby_o(standby_o),
    .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_o(wr_o));
`default_nettype wire

// file: verif/sfp_host.sv
// Serial host model issuing flash instructions
`default_nettype none
module sfp_host (
    input wire logic clock_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic si_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic sel();
        wait_n(1);
        cs_n_o = 1'b0;
        wait_n(4);
    endtask
    // Bits past the eighth are zeros, used to break byte framing
    task automatic bits(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            si_o = (i < 8) ? b[7-i] : 1'b0;
            wait_n(4);
            sclk_o = 1'b1;
            wait_n(4);
            sclk_o = 1'b0;
        end
    endtask
    // Clock stays low and data flips once the device is deselected
    task automatic desel();
        wait_n(4);
        cs_n_o = 1'b1;
        si_o = ~si_o;
        wait_n(12);
    endtask
endmodule // sfp_host
`default_nettype wire

// file: verif/tb_sfp_ctrl.sv
// Self-checking bench for the flash instruction handler
`include "sfp_defines.svh"
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_sfp_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import sfp_pkg::*;
    typedef struct {logic [7:0] op; int n; logic write_enable_latch;} sfp_row_s;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr_ready_i = 1'b0;
    wire logic cs_n, sclk, si;
    logic write_enable_latch, write_in_progress_flag, sleep, stby, wr_valid;
    sfp_wr_s wr;
    int err_count = 0;
    int compares = 0;
    int n;
    sfp_row_s rows[4] = '{'{`SFP_OP_WAKE, 8, 1'b0},
        '{`SFP_OP_WRITE_LATCH_SET, 7, 1'b0},
        '{`SFP_OP_WRITE_LATCH_SET, 8, 1'b1}, '{`SFP_OP_WAKE, 8, 1'b1}};
    always #25 clock_i = ~clock_i;
    sfp_host u_host (.clock_i(clock_i), .cs_n_o(cs_n), .sclk_o(sclk),
        .si_o(si));
    // Short program cycle keeps the run brief; power delays stay real
    sfp_ctrl #(.PROG_CYCLES(200)) dut (.clock_i(clock_i), .rst_i(rst_i),
        .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
        .write_enable_latch_o(write_enable_latch), .write_in_progress_flag_o(write_in_progress_flag),
        .deep_sleep_o(sleep), .standby_o(stby), .wr_valid_o(wr_valid),
        .wr_ready_i(wr_ready_i), .wr_o(wr));
    task automatic cmd(input logic [7:0] op, input int nb);
        u_host.sel();
        u_host.bits(op, nb);
        u_host.desel();
    endtask
    task automatic prog(input logic [23:0] a, input int nb, input int ex);
        u_host.sel();
        u_host.bits(`SFP_OP_PAGE_PROGRAM, 8);
        for (int i = 2; i >= 0; i--) u_host.bits(a[8*i+:8], 8);
        for (int i = 0; i < nb; i++) u_host.bits(8'h5a ^ 8'(i), 8);
        if (ex > 0) u_host.bits(8'hff, ex);
        u_host.desel();
    endtask
    task finish_test;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #(20000 * 50);
        err_count++;
        finish_test();
    end
    initial begin
        repeat (16) @(negedge clock_i);
        rst_i = 1'b0;
        `CHK(stby, 1'b1)
        `CHK(write_enable_latch, 1'b0)
        u_host.wait_n(4);
        foreach (rows[k]) begin
            cmd(rows[k].op, rows[k].n);
            `CHK(write_enable_latch, rows[k].write_enable_latch)
            `CHK(stby, 1'b1)
            $display("row %0d done", k);
        end
        // Array side stalls so the whole page sits in the buffer
        prog(24'h012340, 32, 0);
        `CHK(write_in_progress_flag, 1'b1)
        cmd(`SFP_OP_WAKE, 8);
        `CHK(write_in_progress_flag, 1'b1)
        `CHK(wr_valid, 1'b1)
        n = 0;
        for (int t = 0; t < 400 && n < 32; t++) begin
            // The word standing now is taken at the coming rising edge
            @(negedge clock_i);
            wr_ready_i = t[0];
            if ((wr_valid & wr_ready_i) === 1'b1) begin
                `CHK(wr.addr, 24'(24'h012340 + n))
                `CHK(wr.data, 8'h5a ^ 8'(n))
                n++;
            end
        end
        `CHK(n, 32)
        for (int t = 0; t < 400 && write_in_progress_flag !== 1'b0; t++) u_host.wait_n(1);
        `CHK(write_in_progress_flag, 1'b0)
        `CHK(write_enable_latch, 1'b0)
        $display("page program done");
        prog(24'h000010, 2, 0);
        `CHK(write_in_progress_flag, 1'b0)
        `CHK(wr_valid, 1'b0)
        cmd(`SFP_OP_WRITE_LATCH_SET, 8);
        prog(24'h000020, 1, 4);
        `CHK(write_in_progress_flag, 1'b0)
        $display("refused program done");
        cmd(`SFP_OP_DEEP_SLEEP, 8);
        `CHK(stby, 1'b0)
        `CHK(sleep, 1'b0)
        u_host.wait_n(`SFP_SLEEP_CYCLES);
        `CHK(sleep, 1'b1)
        prog(24'h000030, 1, 0);
        `CHK(write_in_progress_flag, 1'b0)
        cmd(`SFP_OP_WAKE, 9);
        `CHK(sleep, 1'b1)
        cmd(`SFP_OP_WAKE, 8);
        `CHK(stby, 1'b0)
        `CHK(sleep, 1'b0)
        u_host.wait_n(`SFP_WAKE_CYCLES);
        `CHK(stby, 1'b1)
        $display("sleep and wake done");
        rst_i = 1'b1;
        u_host.wait_n(2);
        rst_i = 1'b0;
        `CHK(write_enable_latch, 1'b0)
        `CHK(stby, 1'b1)
        $display("second reset done");
        finish_test();
    end
endmodule // tb_sfp_ctrl
`default_nettype wire
